// >>> hdl/mae_pkg.sv
// package: register map, formats, tables and timing of the mono audio engine
package mae_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_HZ        = 40_000_000;
   localparam int EFFECT_MS     = 100;
   localparam int EFFECT_CYCLES = EFFECT_MS * (CLK_HZ / 1000);

   // ----------------------------------------
   // register map (byte offsets on the register port)
   // ----------------------------------------
   localparam logic [7:0] OFS_EFFECT_SELECT   = 8'h00;
   localparam logic [7:0] OFS_EFFECT_PLAY     = 8'h04;
   localparam logic [7:0] OFS_EFFECT_VOLUME   = 8'h08;
   localparam logic [7:0] OFS_CLIP_START      = 8'h0C;
   localparam logic [7:0] OFS_CLIP_LENGTH     = 8'h10;
   localparam logic [7:0] OFS_CLIP_RATE       = 8'h14;
   localparam logic [7:0] OFS_CLIP_FORMAT     = 8'h18;
   localparam logic [7:0] OFS_CLIP_REPEAT     = 8'h1C;
   localparam logic [7:0] OFS_CLIP_PLAY       = 8'h20;
   localparam logic [7:0] OFS_CLIP_VOLUME     = 8'h24;
   localparam logic [7:0] OFS_CLIP_READ_PTR   = 8'h28;

   localparam int ADDR_W = 20;

   // ----------------------------------------
   // effects and synthesis
   // ----------------------------------------
   localparam logic [7:0]  EFFECT_SILENCE    = 8'h00;
   localparam logic [7:0]  EFFECT_ONESHOT_MIN = 8'h40;
   localparam logic [23:0] NOTE_BASE_INC     = 24'h00006E;
   localparam logic [23:0] NOTE_STEP_INC     = 24'h000007;
   localparam logic [23:0] FIX_STEP_INC      = 24'h000010;
   localparam logic [7:0]  PWM_MID           = 8'h80;

   localparam logic [7:0] SINE_ROM [0:15] = '{
      8'h00, 8'h30, 8'h5A, 8'h76, 8'h7F, 8'h76, 8'h5A, 8'h30,
      8'h00, 8'hD0, 8'hA6, 8'h8A, 8'h81, 8'h8A, 8'hA6, 8'hD0};

   // ----------------------------------------
   // clip formats and decoder tables
   // ----------------------------------------
   typedef enum logic [1:0] {
      FMT_LINEAR = 2'b00,
      FMT_MULAW  = 2'b01,
      FMT_ADPCM  = 2'b10
   } mae_fmt_t;

   localparam logic [15:0] MULAW_BIAS = 16'h0084;
   localparam logic [6:0]  ADPCM_IDX_MAX = 7'h58;

   localparam logic [14:0] ADPCM_STEP [0:88] = '{
      15'h7,15'h8,15'h9,15'hA,15'hB,15'hC,15'hD,15'hE,15'h10,15'h11,15'h13,15'h15,
      15'h17,15'h19,15'h1C,15'h1F,15'h22,15'h25,15'h29,15'h2D,15'h32,15'h37,15'h3C,
      15'h42,15'h49,15'h50,15'h58,15'h61,15'h6B,15'h76,15'h82,15'h8F,15'h9D,15'hAD,
      15'hBE,15'hD1,15'hE6,15'hFD,15'h117,15'h133,15'h151,15'h173,15'h198,15'h1C1,
      15'h1EE,15'h220,15'h256,15'h292,15'h2D4,15'h31C,15'h36C,15'h3C3,15'h424,
      15'h48E,15'h502,15'h583,15'h610,15'h6AB,15'h756,15'h812,15'h8E0,15'h9C3,
      15'hABD,15'hBD0,15'hCFF,15'hE4C,15'hFBA,15'h114C,15'h1307,15'h14EE,15'h1706,
      15'h1954,15'h1BDC,15'h1EA5,15'h21B6,15'h2515,15'h28CA,15'h2CDF,15'h315B,
      15'h364B,15'h3BB9,15'h41B2,15'h4844,15'h4F7E,15'h5771,15'h602F,15'h69CE,
      15'h7462,15'h7FFF};

   localparam logic [3:0] ADPCM_IDX_ADJ [0:7] = '{
      4'hF, 4'hF, 4'hF, 4'hF, 4'h2, 4'h4, 4'h6, 4'h8};

   // ----------------------------------------
   // register port carrier
   // ----------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } mae_req_t;

endpackage

// >>> hdl/mae_audio_engine.sv
// module: mono audio engine with effect synthesizer, clip playback and pwm output
`timescale 1ns/1ps

// Operation
// R1: mono audio as pwm on one pin
// R2: output mixes synthesizer and clip playback
// R3: effects come from small wave-table rom
// R4: select code then write 1 starts effect
// R5: effect trigger reads 1 while sounding
// R6: some effects loop; new trigger replaces effect
// R7: code 0 with trigger stops effect
// R8: effect select is 16 bits, code low
// R9: upper byte is note for pitch effects
// R10: effect volume scales synthesized effects
// R11: clip read from ram, start and length
// R12: clip samples consumed at programmed hertz rate
// R13: format register picks one of three
// R14: 8-bit linear, 8-bit mu-law, 4-bit adpcm
// R15: repeat 0 plays once, 1 loops
// R16: any write to clip trigger starts
// R17: clip trigger reads 1 while playing
// R18: clip volume 0 to 255 scales playback
// R19: adpcm low nibble first, high second
// R20: host reads back clip read pointer
// R21: host refills looping buffer using pointer
// R22: pointer advances, wraps to start when looping
// R23: finished clip goes silent, status clears
module mae_audio_engine
   import mae_pkg::*;
#(
   parameter int EFFECT_LEN = EFFECT_CYCLES
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   // register port
   input  wire mae_req_t          req_in,
   output logic [31:0]            rdata_out,
   output logic                   rvalid_out,
   // clip ram read port, data one cycle after the strobe
   output logic [ADDR_W-1:0]      ram_addr_out,
   output logic                   ram_rd_out,
   input  wire logic [7:0]        ram_data_in,
   // audio pin
   output logic                   audio_pwm_out
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   typedef enum logic [1:0] {
      C_IDLE  = 2'b00,
      C_RUN   = 2'b01,
      C_FETCH = 2'b10,
      C_LOAD  = 2'b11
   } mae_cstate_t;

   logic [15:0]        effect_select_reg;
   logic [7:0]         effect_volume_reg;
   logic [ADDR_W-1:0]  clip_start_reg;
   logic [ADDR_W-1:0]  clip_length_reg;
   logic [15:0]        clip_rate_reg;
   mae_fmt_t           clip_format_reg;
   logic               clip_repeat_reg;
   logic [7:0]         clip_volume_reg;

   logic               eff_active_reg;
   logic [7:0]         eff_code_reg;
   logic [7:0]         eff_note_reg;
   logic [23:0]        eff_phase_reg;
   logic [31:0]        eff_dur_reg;

   mae_cstate_t        cstate_reg;
   logic               clip_active_reg;
   logic [ADDR_W-1:0]  clip_ptr_reg;
   logic [ADDR_W-1:0]  clip_remain_reg;
   logic [26:0]        rate_acc_reg;
   logic [7:0]         byte_reg;
   logic               nib_hi_reg;
   logic               last_reg;
   logic [15:0]        pred_reg;
   logic [6:0]         idx_reg;
   logic [15:0]        sample_reg;
   logic [7:0]         level_reg;
   logic [7:0]         pwm_cnt_reg;

   logic               wr_eff_play;
   logic               wr_clip_play;
   logic               eff_oneshot;
   logic [23:0]        eff_inc;
   logic [26:0]        rate_sum;
   logic               tick;
   logic               is_adpcm;

   assign wr_eff_play  = req_in.wr && req_in.addr == OFS_EFFECT_PLAY;
   assign wr_clip_play = req_in.wr && req_in.addr == OFS_CLIP_PLAY;
   assign eff_oneshot  = eff_code_reg >= EFFECT_ONESHOT_MIN;
   assign is_adpcm     = clip_format_reg == FMT_ADPCM;
   assign rate_sum     = rate_acc_reg + {11'h000, clip_rate_reg};
   assign tick         = rate_sum >= 27'(CLK_HZ);

   // ----------------------------------------
   // decoders
   // ----------------------------------------
   function automatic logic [15:0] mulaw_dec(input logic [7:0] b);
      logic [7:0]  u;
      logic [15:0] t;
      logic [15:0] mag;
      u   = ~b;
      t   = ({9'h000, u[3:0], 3'h0} + MULAW_BIAS) << u[6:4];
      mag = t - MULAW_BIAS;
      return u[7] ? 16'(-mag) : mag;
   endfunction

   function automatic logic [22:0] adpcm_dec(input logic [3:0] c,
                                             input logic [15:0] pred,
                                             input logic [6:0] idx);
      logic [15:0] step;
      logic [16:0] diff;
      logic [17:0] sum;
      logic [7:0]  ni;
      step = {1'b0, ADPCM_STEP[idx]};
      diff = {4'h0, step[15:3]};
      if (c[2]) begin
         diff = diff + {1'b0, step};
      end
      if (c[1]) begin
         diff = diff + {2'h0, step[15:1]};
      end
      if (c[0]) begin
         diff = diff + {3'h0, step[15:2]};
      end
      sum = c[3] ? {{2{pred[15]}}, pred} - {1'b0, diff}
                 : {{2{pred[15]}}, pred} + {1'b0, diff};
      if ($signed(sum) > $signed(18'h07FFF)) begin
         sum = 18'h07FFF;
      end else if ($signed(sum) < $signed(18'h38000)) begin
         sum = 18'h38000;
      end
      ni = {1'b0, idx} + {{4{ADPCM_IDX_ADJ[c[2:0]][3]}}, ADPCM_IDX_ADJ[c[2:0]]};
      if (ni[7]) begin
         ni = 8'h00;
      end else if (ni > {1'b0, ADPCM_IDX_MAX}) begin
         ni = {1'b0, ADPCM_IDX_MAX};
      end
      return {sum[15:0], ni[6:0]};
   endfunction

   // ----------------------------------------
   // host registers
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         effect_select_reg <= 16'h0000;
         effect_volume_reg <= 8'h00;
         clip_start_reg    <= '0;
         clip_length_reg   <= '0;
         clip_rate_reg     <= 16'h0000;
         clip_format_reg   <= FMT_LINEAR;
         clip_repeat_reg   <= 1'b0;
         clip_volume_reg   <= 8'h00;
      end else if (req_in.wr) begin
         case (req_in.addr)
            OFS_EFFECT_SELECT: effect_select_reg <= req_in.wdata[15:0];  // R8
            OFS_EFFECT_VOLUME: effect_volume_reg <= req_in.wdata[7:0];
            OFS_CLIP_START:    clip_start_reg    <= req_in.wdata[ADDR_W-1:0];
            OFS_CLIP_LENGTH:   clip_length_reg   <= req_in.wdata[ADDR_W-1:0];
            OFS_CLIP_RATE:     clip_rate_reg     <= req_in.wdata[15:0];
            OFS_CLIP_FORMAT: begin
               if (req_in.wdata[1:0] != 2'b11) begin
                  clip_format_reg <= mae_fmt_t'(req_in.wdata[1:0]);  // R13
               end
            end
            OFS_CLIP_REPEAT:   clip_repeat_reg   <= req_in.wdata[0];
            OFS_CLIP_VOLUME:   clip_volume_reg   <= req_in.wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_out  <= 32'h00000000;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= req_in.rd;
         case (req_in.addr)
            OFS_EFFECT_SELECT: rdata_out <= {16'h0000, effect_select_reg};
            OFS_EFFECT_PLAY:   rdata_out <= {31'h0, eff_active_reg};  // R5
            OFS_EFFECT_VOLUME: rdata_out <= {24'h0, effect_volume_reg};
            OFS_CLIP_START:    rdata_out <= 32'(clip_start_reg);
            OFS_CLIP_LENGTH:   rdata_out <= 32'(clip_length_reg);
            OFS_CLIP_RATE:     rdata_out <= {16'h0000, clip_rate_reg};
            OFS_CLIP_FORMAT:   rdata_out <= {30'h0, clip_format_reg};
            OFS_CLIP_REPEAT:   rdata_out <= {31'h0, clip_repeat_reg};
            OFS_CLIP_PLAY:     rdata_out <= {31'h0, clip_active_reg};  // R17
            OFS_CLIP_VOLUME:   rdata_out <= {24'h0, clip_volume_reg};
            OFS_CLIP_READ_PTR: rdata_out <= 32'(clip_ptr_reg);  // R20 R21
            default:           rdata_out <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // effect synthesizer
   // ----------------------------------------
   assign eff_inc = eff_oneshot ? 24'(eff_code_reg * FIX_STEP_INC)  // R9
                                : 24'(NOTE_BASE_INC + eff_note_reg * NOTE_STEP_INC);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         eff_active_reg <= 1'b0;
         eff_code_reg   <= EFFECT_SILENCE;
         eff_note_reg   <= 8'h00;
         eff_phase_reg  <= 24'h000000;
         eff_dur_reg    <= 32'h00000000;
      end else if (wr_eff_play && req_in.wdata[0]) begin
         eff_code_reg   <= effect_select_reg[7:0];  // R4 R6
         eff_note_reg   <= effect_select_reg[15:8];
         eff_active_reg <= effect_select_reg[7:0] != EFFECT_SILENCE;  // R7
         eff_phase_reg  <= 24'h000000;
         eff_dur_reg    <= 32'h00000000;
      end else if (eff_active_reg) begin
         eff_phase_reg <= eff_phase_reg + eff_inc;
         if (eff_oneshot) begin
            eff_dur_reg <= eff_dur_reg + 32'h1;
            if (eff_dur_reg == 32'(EFFECT_LEN - 1)) begin
               eff_active_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // clip playback
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in || cstate_reg == C_IDLE) begin
         rate_acc_reg <= 27'h0;
      end else if (tick) begin
         rate_acc_reg <= rate_sum - 27'(CLK_HZ);  // R12
      end else begin
         rate_acc_reg <= rate_sum;
      end
   end

   always_ff @(posedge clk_in) begin
      logic [22:0] dec;
      dec = 23'h0;
      if (reset_in) begin
         cstate_reg      <= C_IDLE;
         clip_active_reg <= 1'b0;
         clip_ptr_reg    <= '0;
         clip_remain_reg <= '0;
         byte_reg        <= 8'h00;
         nib_hi_reg      <= 1'b0;
         last_reg        <= 1'b0;
         pred_reg        <= 16'h0000;
         idx_reg         <= 7'h00;
         sample_reg      <= 16'h0000;
         ram_rd_out      <= 1'b0;
         ram_addr_out    <= '0;
      end else begin
         ram_rd_out <= 1'b0;
         if (wr_clip_play) begin
            cstate_reg      <= clip_length_reg != '0 ? C_RUN : C_IDLE;  // R16
            clip_active_reg <= clip_length_reg != '0;
            clip_ptr_reg    <= clip_start_reg;
            clip_remain_reg <= clip_length_reg;
            nib_hi_reg      <= 1'b0;
            last_reg        <= 1'b0;
            pred_reg        <= 16'h0000;
            idx_reg         <= 7'h00;
            sample_reg      <= 16'h0000;
         end else begin
            case (cstate_reg)
               C_RUN: begin
                  if (tick && is_adpcm && nib_hi_reg) begin
                     dec        = adpcm_dec(byte_reg[7:4], pred_reg, idx_reg);  // R19
                     pred_reg   <= dec[22:7];
                     idx_reg    <= dec[6:0];
                     sample_reg <= dec[22:7];
                     nib_hi_reg <= 1'b0;
                     if (last_reg && !clip_repeat_reg) begin
                        cstate_reg      <= C_IDLE;  // R23
                        clip_active_reg <= 1'b0;
                        sample_reg      <= 16'h0000;
                     end
                  end else if (tick) begin
                     ram_rd_out   <= 1'b1;  // R11
                     ram_addr_out <= clip_ptr_reg;
                     cstate_reg   <= C_FETCH;
                  end
               end
               C_FETCH: cstate_reg <= C_LOAD;
               C_LOAD: begin
                  cstate_reg <= C_RUN;
                  byte_reg   <= ram_data_in;
                  last_reg   <= clip_remain_reg == ADDR_W'(1);
                  if (clip_remain_reg == ADDR_W'(1) && clip_repeat_reg) begin
                     clip_ptr_reg    <= clip_start_reg;  // R15 R22
                     clip_remain_reg <= clip_length_reg;
                  end else begin
                     clip_ptr_reg    <= clip_ptr_reg + ADDR_W'(1);  // R22
                     clip_remain_reg <= clip_remain_reg - ADDR_W'(1);
                  end
                  case (clip_format_reg)  // R14
                     FMT_ADPCM: begin
                        dec        = adpcm_dec(ram_data_in[3:0], pred_reg, idx_reg);  // R19
                        pred_reg   <= dec[22:7];
                        idx_reg    <= dec[6:0];
                        sample_reg <= dec[22:7];
                        nib_hi_reg <= 1'b1;
                     end
                     FMT_MULAW: sample_reg <= mulaw_dec(ram_data_in);
                     default:   sample_reg <= {ram_data_in, 8'h00};
                  endcase
                  if (!is_adpcm && clip_remain_reg == ADDR_W'(1) && !clip_repeat_reg) begin
                     cstate_reg      <= C_IDLE;  // R23
                     clip_active_reg <= 1'b0;
                     sample_reg      <= 16'h0000;
                  end
               end
               default: cstate_reg <= C_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // mixer and pwm
   // ----------------------------------------
   logic signed [16:0] eff_prod;
   logic signed [16:0] clip_prod;
   logic signed [9:0]  mix_sum;
   logic [7:0]         eff_wave;

   assign eff_wave  = eff_active_reg ? SINE_ROM[eff_phase_reg[23:20]] : 8'h00;  // R3
   assign eff_prod  = $signed(eff_wave) * $signed({1'b0, effect_volume_reg});  // R10
   assign clip_prod = $signed(sample_reg[15:8]) * $signed({1'b0, clip_volume_reg});  // R18
   assign mix_sum   = 10'(eff_prod[16:8]) + 10'(clip_prod[16:8]);  // R2

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         level_reg     <= PWM_MID;
         pwm_cnt_reg   <= 8'h00;
         audio_pwm_out <= 1'b0;
      end else begin
         level_reg     <= mix_sum[8:1] + PWM_MID;
         pwm_cnt_reg   <= pwm_cnt_reg + 8'h01;
         audio_pwm_out <= pwm_cnt_reg < level_reg;  // R1
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   property p_pwm;
      !$past(reset_in) |-> audio_pwm_out == $past(pwm_cnt_reg < level_reg);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm pin wrong");  // R1

   property p_eff_start;
      wr_eff_play && req_in.wdata[0] && effect_select_reg[7:0] != EFFECT_SILENCE
         |=> eff_active_reg && eff_code_reg == $past(effect_select_reg[7:0]);
   endproperty
   a_eff_start: assert property (p_eff_start) else $error("effect not started");  // R4

   property p_eff_stop;
      wr_eff_play && req_in.wdata[0] && effect_select_reg[7:0] == EFFECT_SILENCE
         |=> !eff_active_reg ##1 !eff_active_reg || $past(wr_eff_play);
   endproperty
   a_eff_stop: assert property (p_eff_stop) else $error("silence did not stop");  // R7

   property p_eff_read;
      req_in.rd && req_in.addr == OFS_EFFECT_PLAY
         |=> rvalid_out && rdata_out == {31'h0, $past(eff_active_reg)};
   endproperty
   a_eff_read: assert property (p_eff_read) else $error("effect status read");  // R5

   property p_clip_start;
      wr_clip_play && clip_length_reg != '0
         |=> clip_active_reg && clip_ptr_reg == $past(clip_start_reg);
   endproperty
   a_clip_start: assert property (p_clip_start) else $error("clip not started");  // R16

   property p_clip_read;
      req_in.rd && req_in.addr == OFS_CLIP_PLAY
         |=> rdata_out[0] == $past(clip_active_reg);
   endproperty
   a_clip_read: assert property (p_clip_read) else $error("clip status read");  // R17

   property p_clip_end;
      cstate_reg == C_LOAD && !is_adpcm && !clip_repeat_reg && !wr_clip_play
         && clip_remain_reg == ADDR_W'(1)
         |=> !clip_active_reg && sample_reg == 16'h0000 ##1 cstate_reg == C_IDLE
             || $past(wr_clip_play);
   endproperty
   a_clip_end: assert property (p_clip_end) else $error("clip did not end");  // R23

   property p_clip_wrap;
      cstate_reg == C_LOAD && clip_repeat_reg && !wr_clip_play
         && clip_remain_reg == ADDR_W'(1)
         |=> clip_ptr_reg == $past(clip_start_reg) && clip_active_reg;
   endproperty
   a_clip_wrap: assert property (p_clip_wrap) else $error("clip did not wrap");  // R22

   property p_fetch;
      cstate_reg == C_RUN && tick && !(is_adpcm && nib_hi_reg) && !wr_clip_play
         |=> ram_rd_out && ram_addr_out == $past(clip_ptr_reg) ##2 cstate_reg != C_FETCH;
   endproperty
   a_fetch: assert property (p_fetch) else $error("ram fetch wrong");  // R11

endmodule

// >>> test/mae_partner.sv
// far side models: audio filter on the pwm pin and clip ram
`timescale 1ns/1ps

module mae_audio_filter (
   // clock and pin
   input  wire logic       clk_in,
   input  wire logic       audio_pwm_in,
   // averaged level, high cycles per 256 clocks
   output logic [8:0]      duty_out
);
   logic [7:0] win_reg;
   logic [8:0] acc_reg;
   initial begin
      win_reg  = 8'h00;
      acc_reg  = 9'h000;
      duty_out = 9'h000;
   end
   // one pwm period is 256 clocks, so a full window gives the level
   always @(posedge clk_in) begin
      win_reg <= win_reg + 8'h01;
      if (win_reg == 8'hFF) begin
         duty_out <= acc_reg + {8'h00, audio_pwm_in};
         acc_reg  <= 9'h000;
      end else begin
         acc_reg  <= acc_reg + {8'h00, audio_pwm_in};
      end
   end
endmodule

module mae_clip_ram
   import mae_pkg::*;
(
   // clock and read port
   input  wire logic              clk_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic              rd_in,
   output logic [7:0]             data_out
);
   logic [7:0] mem [0:255];
   int         reads;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = (i < 128) ? 8'h7F : 8'h00;
      end
      data_out = 8'h00;
      reads    = 0;
   end
   // data valid one cycle after the strobe, otherwise toggles
   always @(posedge clk_in) begin
      if (rd_in) begin
         data_out <= mem[addr_in[7:0]];
         reads    <= reads + 1;
      end else begin
         data_out <= ~data_out;
      end
   end
endmodule

// >>> test/mae_audio_engine_test.sv
// testbench: register sequences against the mono audio engine
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module mae_audio_engine_test
   import mae_pkg::*;
;
   logic              clk_in;
   logic              reset_in;
   mae_req_t          req;
   logic [31:0]       rdata_out;
   logic              rvalid_out;
   logic [ADDR_W-1:0] ram_addr_out;
   logic              ram_rd_out;
   logic [7:0]        ram_data;
   logic              audio_pwm_out;
   logic [8:0]        duty;
   logic [31:0]       v;
   int                miscompares;
   int                checks_done;
   int                r0;

   mae_audio_engine #(.EFFECT_LEN(50)) u_mae_audio_engine (
      .clk_in(clk_in), .reset_in(reset_in), .req_in(req),
      .rdata_out(rdata_out), .rvalid_out(rvalid_out),
      .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out),
      .ram_data_in(ram_data), .audio_pwm_out(audio_pwm_out));
   mae_clip_ram u_mae_clip_ram (.clk_in(clk_in), .addr_in(ram_addr_out),
      .rd_in(ram_rd_out), .data_out(ram_data));
   mae_audio_filter u_mae_audio_filter (.clk_in(clk_in),
      .audio_pwm_in(audio_pwm_out), .duty_out(duty));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic test_done();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_in) req = '{1'b1, 1'b0, a, d};
      @(negedge clk_in) req = '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk_in) req = '{1'b0, 1'b1, a, 32'h0000_0000};
      @(negedge clk_in) req = '0;
      `CHK(rvalid_out, 1'b1)
      d = rdata_out;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   initial begin
      #(25ns * 40000);
      miscompares++;
      test_done();
   end

   initial begin
      miscompares = 0;
      checks_done = 0;
      reset_in    = 1'b1;
      req         = '0;
      idle(2);
      reset_in = 1'b0;
      rc(OFS_EFFECT_PLAY, 32'h0);
      rc(OFS_CLIP_PLAY, 32'h0);
      idle(600);
      `CHK(duty, 9'h080)
      wr(OFS_EFFECT_SELECT, 32'h0000_1234);
      rc(OFS_EFFECT_SELECT, 32'h0000_1234);
      rc(8'h3C, 32'h0);
      wr(OFS_EFFECT_VOLUME, 32'h0000_00FF);
      rc(OFS_EFFECT_VOLUME, 32'h0000_00FF);
      wr(OFS_EFFECT_SELECT, 32'h0000_0540);
      wr(OFS_EFFECT_PLAY, 32'h1);
      rc(OFS_EFFECT_PLAY, 32'h1);
      idle(60);
      rc(OFS_EFFECT_PLAY, 32'h0);
      wr(OFS_EFFECT_SELECT, 32'h0000_0C01);
      wr(OFS_EFFECT_PLAY, 32'h1);
      idle(100);
      rc(OFS_EFFECT_PLAY, 32'h1);
      wr(OFS_EFFECT_SELECT, 32'h0);
      wr(OFS_EFFECT_PLAY, 32'h1);
      rc(OFS_EFFECT_PLAY, 32'h0);
      for (int f = 0; f < 3; f++) begin
         wr(OFS_CLIP_FORMAT, f);
         rc(OFS_CLIP_FORMAT, f);
      end
      wr(OFS_CLIP_FORMAT, 32'h3);
      rc(OFS_CLIP_FORMAT, 32'h2);
      wr(OFS_CLIP_FORMAT, 32'h0);
      wr(OFS_CLIP_START, 32'h10);
      wr(OFS_CLIP_LENGTH, 32'h4);
      wr(OFS_CLIP_RATE, 32'hFFFF);
      wr(OFS_CLIP_VOLUME, 32'hFF);
      rc(OFS_CLIP_VOLUME, 32'hFF);
      r0 = u_mae_clip_ram.reads;
      wr(OFS_CLIP_PLAY, 32'h0);
      rc(OFS_CLIP_PLAY, 32'h1);
      idle(1300);
      `CHK(duty, 9'h0BF)
      idle(1900);
      rc(OFS_CLIP_PLAY, 32'h0);
      rc(OFS_CLIP_READ_PTR, 32'h14);
      `CHK(u_mae_clip_ram.reads - r0, 4)
      idle(600);
      `CHK(duty, 9'h080)
      wr(OFS_CLIP_FORMAT, 32'h2);
      wr(OFS_CLIP_LENGTH, 32'h2);
      r0 = u_mae_clip_ram.reads;
      wr(OFS_CLIP_PLAY, 32'h1);
      idle(3200);
      rc(OFS_CLIP_PLAY, 32'h0);
      rc(OFS_CLIP_READ_PTR, 32'h12);
      `CHK(u_mae_clip_ram.reads - r0, 2)
      wr(OFS_CLIP_FORMAT, 32'h0);
      wr(OFS_CLIP_REPEAT, 32'h1);
      r0 = u_mae_clip_ram.reads;
      wr(OFS_CLIP_PLAY, 32'h1);
      idle(3500);
      rc(OFS_CLIP_PLAY, 32'h1);
      rd(OFS_CLIP_READ_PTR, v);
      `CHK(v >= 32'h10 && v <= 32'h14, 1'b1)
      `CHK(u_mae_clip_ram.reads - r0 > 4, 1'b1)
      wr(OFS_CLIP_REPEAT, 32'h0);
      idle(3200);
      rc(OFS_CLIP_PLAY, 32'h0);
      wr(OFS_CLIP_FORMAT, 32'h1);
      wr(OFS_CLIP_START, 32'h80);
      wr(OFS_CLIP_LENGTH, 32'h4);
      wr(OFS_CLIP_PLAY, 32'h1);
      idle(1300);
      `CHK(duty, 9'h041)
      idle(1900);
      rc(OFS_CLIP_PLAY, 32'h0);
      rc(OFS_CLIP_READ_PTR, 32'h84);
      test_done();
   end
endmodule
